// file: rsel_pkg.sv
package rsel_pkg;

  // Inputs: first, second, standby
  localparam int NUM_IN = 3;
  localparam int CNT_W = 16;

  // Register map
  localparam logic [7:0] ADDR_INT_STATUS = 8'h06;
  localparam logic [7:0] ADDR_OP_STATE = 8'h09;
  localparam logic [7:0] ADDR_VALID_LO = 8'h0E;
  localparam logic [7:0] ADDR_VALID_HI = 8'h0F;
  localparam logic [7:0] ADDR_PRIO_A = 8'h19;
  localparam logic [7:0] ADDR_PRIO_B = 8'h1A;
  localparam logic [7:0] ADDR_PRIO_C = 8'h1C;
  localparam logic [7:0] ADDR_FORCE_STATE = 8'h32;
  localparam logic [7:0] ADDR_FORCE_INPUT = 8'h33;
  localparam logic [7:0] ADDR_TOL_ONE = 8'h41;
  localparam logic [7:0] ADDR_TOL_TWO = 8'h42;
  localparam logic [7:0] ADDR_MON_CFG = 8'h48;
  localparam logic [7:0] ADDR_PHASE_CFG = 8'h73;

  // Field positions
  localparam int INT_LOST_BIT = 6;
  localparam int MON_EXT_BIT = 4;
  localparam int MON_UF_BIT = 5;
  localparam int MON_TDO_BIT = 6;
  localparam int PHASE_LOST_EN_BIT = 6;
  localparam int REVERT_BIT = 3;

  // Reset values
  localparam logic [7:0] PRIO_A_RST = 8'h21;
  localparam logic [7:0] PRIO_B_RST = 8'h03;
  localparam logic [7:0] PRIO_C_RST = 8'h00;
  localparam logic [7:0] FORCE_STATE_RST = 8'h08;
  localparam logic [7:0] FORCE_INPUT_RST = 8'h0F;
  localparam logic [7:0] MON_CFG_RST = 8'h00;
  localparam logic [7:0] PHASE_CFG_RST = 8'h00;
  localparam logic [7:0] TOL_NORMAL_CODE = 8'h01;
  localparam logic [7:0] TOL_WIDE_CODE = 8'h02;

  // Selection encodings
  localparam logic [3:0] FORCE_AUTO_ZERO = 4'h0;
  localparam logic [3:0] FORCE_AUTO_ONES = 4'hF;
  localparam logic [3:0] PRIO_OFF = 4'h0;
  localparam logic [1:0] SEL_FIRST = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;

  // Operating state report codes
  localparam logic [2:0] OPS_HOLDOVER = 3'h2;
  localparam logic [2:0] OPS_LOCKED = 3'h4;
  localparam logic [2:0] OPS_LOST_PHASE = 3'h5;

  // Timing: loss after two missing 8 kHz periods
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_PERIOD_NS = 125000;
  localparam int LOSS_PERIODS = 2;
  localparam int LOSS_CYCLES_DEF = LOSS_PERIODS * REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] STRAP_DELAY = 3'h5;

endpackage

// file: rsel_act_mon.sv
`timescale 1ns/1ps
`default_nettype none

module rsel_act_mon
  import rsel_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOSS_CYCLES = CNT_W'(LOSS_CYCLES_DEF)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ref_pin,
  output logic ref_lost
);

  logic [2:0] sync_q;
  logic level_q;
  logic [CNT_W-1:0] gap_q;
  wire agree = (sync_q[1] == sync_q[2]);
  wire rise = agree & sync_q[2] & ~level_q;

  // Three stages; a change counts once the last two agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], ref_pin};
      if (agree) begin
        level_q <= sync_q[2];
      end
    end
  end

  // Cycles since last rising edge; saturates so a dead input stays lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gap_q <= '0;
      ref_lost <= 1'b0;
    end else if (rise) begin
      gap_q <= '0;
      ref_lost <= 1'b0;
    end else if (gap_q != LOSS_CYCLES) begin
      gap_q <= gap_q + CNT_W'(1);
    end else begin
      ref_lost <= 1'b1;
    end
  end

  property p_lost_clears;
    @(posedge clk_sys) disable iff (reset)
      rise |=> !ref_lost;
  endproperty
  a_lost_clears: assert property (p_lost_clears) else $error("loss flag kept after edge");

endmodule

`default_nettype wire

// file: rsel_selector.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Two missing cycles on selected input raise no-activity and freeze the loop.
// - No-activity readable in status bit 6; phase-lost report when enabled.
// - Input returning before slow alarm is kept, no switch.
// - Locked loop uses nearest-edge capture, half-cycle window.
// - Auto mode picks best-priority valid input, then next best.
// - Revertive: switch to revalidated input of better priority.
// - Non-revertive: keep current input, flag revalidation in interrupt status bits 2:0.
// - Failing selected input causes a switch away in auto mode when another input is valid.
// - Force field all zeros or ones means automatic; resets to ones.
// - Four-bit priority per input, lower is better, zero excludes.
// - Equal priorities ordered first in first out, revertive ignored.
// - Frame-sync follows its paired clock selection and priority.
// - Ultra-fast bit: short loss switches input and sets lost flag.
// - TDO mirror of lost flag when enabled; off after reset.
// - External switching by pin high at reset or config bit 4.
// - External mode: pin high selects first input, low second.
// - Strap entry sets inputs one and two tolerance to wide default.
// - Zero single-ended priority on input one or two routes the differential variant.
// - External mode: monitoring off, loop forced locked, state reads locked.
module rsel_selector
  import rsel_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOSS_CYCLES = CNT_W'(LOSS_CYCLES_DEF)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [NUM_IN-1:0] ref_in,
  input wire logic [1:0] differential_variant,
  input wire logic [NUM_IN-1:0] slow_alarm,
  input wire logic protection_switch_pin,
  input wire logic jtag_tdo,
  input wire logic jtag_tdo_oe,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic [1:0] ref_select,
  output logic ref_select_valid,
  output logic ref_use_differential,
  output logic [1:0] sync_select,
  output logic no_activity,
  output logic pll_holdover,
  output logic pll_nearest_edge,
  output logic tdo_out,
  output logic tdo_oe
);

  logic [7:0] prio_a_q, prio_b_q, prio_c_q, force_state_q, force_input_q;
  logic [7:0] tol_one_q, tol_two_q, mon_cfg_q, phase_cfg_q;
  logic lost_flag_q;
  logic [NUM_IN-1:0] reval_q, valid_q;
  logic [1:0] sel_q, sel_d;
  logic sel_ok_q, sel_ok_d;
  logic [1:0] pos_q [NUM_IN], pos_d [NUM_IN];
  logic [2:0] sw_sync_q;
  logic sw_q, strap_q;
  logic [2:0] init_cnt_q;

  // Priority nibbles per input
  wire [3:0] prio [NUM_IN];
  assign prio[0] = prio_a_q[3:0];
  assign prio[1] = prio_a_q[7:4];
  assign prio[2] = prio_b_q[3:0];

  // Mode decode
  wire ext_mode = strap_q | mon_cfg_q[MON_EXT_BIT];
  wire uf_en = mon_cfg_q[MON_UF_BIT];
  wire tdo_en = mon_cfg_q[MON_TDO_BIT];
  wire revert = force_state_q[REVERT_BIT];
  wire [3:0] force_field = force_input_q[3:0];
  wire forced = (force_field != FORCE_AUTO_ZERO) && (force_field != FORCE_AUTO_ONES);
  wire automatic_sel = !ext_mode && !forced;

  // Differential routing for the first two inputs
  wire [1:0] use_differential_variant = {prio[1] == PRIO_OFF, prio[0] == PRIO_OFF};
  wire [NUM_IN-1:0] routed = {ref_in[2],
                              use_differential_variant[1] ? differential_variant[1] : ref_in[1],
                              use_differential_variant[0] ? differential_variant[0] : ref_in[0]};

  logic [NUM_IN-1:0] lost;
  generate
    for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_mon
      rsel_act_mon #(
        .LOSS_CYCLES(LOSS_CYCLES)
      ) u_mon (
        .clk_sys(clk_sys),
        .reset(reset),
        .ref_pin(routed[gi]),
        .ref_lost(lost[gi])
      );
    end
  endgenerate

  // Validity; ultra-fast lets a short loss disqualify too
  wire [NUM_IN-1:0] valid_now = ~slow_alarm & ~(lost & {NUM_IN{uf_en}});
  wire [NUM_IN-1:0] elig = valid_now & {prio[2] != PRIO_OFF, prio[1] != PRIO_OFF,
                                        prio[0] != PRIO_OFF};
  wire [NUM_IN-1:0] rise = valid_now & ~valid_q;
  wire [NUM_IN-1:0] fall = valid_q & ~valid_now;

  // Count of set bits among a masked three-bit vector
  function automatic logic [1:0] count3(input logic [NUM_IN-1:0] v);
    logic [1:0] c;
    c = 2'h0;
    for (int k = 0; k < NUM_IN; k++) begin
      c = c + {1'b0, v[k]};
    end
    return c;
  endfunction

  // Queue order for equal priorities: newcomers join at the back
  logic [NUM_IN-1:0] stay, early, ahead_gone;
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      stay = valid_q & valid_now;
      stay[i] = 1'b0;
      early = '0;
      ahead_gone = '0;
      for (int j = 0; j < NUM_IN; j++) begin
        early[j] = rise[j] && (j < i);
        ahead_gone[j] = fall[j] && (pos_q[j] < pos_q[i]);
      end
      if (rise[i]) begin
        pos_d[i] = count3(stay) + count3(early);
      end else if (valid_now[i]) begin
        pos_d[i] = pos_q[i] - count3(ahead_gone);
      end else begin
        pos_d[i] = pos_q[i];
      end
    end
  end

  // Best eligible input by {priority, queue place}; lowest channel number wins exact ties
  function automatic logic [2:0] pick_best(input logic [NUM_IN-1:0] el,
                                           input logic [6*NUM_IN-1:0] keys);
    logic found;
    logic [1:0] idx;
    logic [5:0] best_key;
    found = 1'b0;
    idx = 2'h0;
    best_key = 6'h3F;
    for (int k = 0; k < NUM_IN; k++) begin
      if (el[k] && (!found || keys[6*k +: 6] < best_key)) begin
        found = 1'b1;
        idx = 2'(k);
        best_key = keys[6*k +: 6];
      end
    end
    return {found, idx};
  endfunction

  wire [6*NUM_IN-1:0] keys = {prio[2], pos_q[2], prio[1], pos_q[1], prio[0], pos_q[0]};
  wire [2:0] best = pick_best(elig, keys);
  wire best_found = best[2];
  wire [1:0] best_idx = best[1:0];
  wire cur_ok = sel_ok_q && elig[sel_q];
  wire better = best_found && (prio[best_idx] < prio[sel_q]);
  wire lost_sel = sel_ok_q && lost[sel_q] && !ext_mode;

  // Next selection: external pin, then forced, then automatic
  always_comb begin
    sel_d = sel_q;
    sel_ok_d = sel_ok_q;
    if (ext_mode) begin
      sel_d = sw_q ? SEL_FIRST : SEL_SECOND;
      sel_ok_d = 1'b1;
    end else if (forced) begin
      sel_d = 2'(force_field - 4'h1);
      sel_ok_d = (force_field <= 4'(NUM_IN));
    end else if (!cur_ok) begin
      sel_d = best_idx;
      sel_ok_d = best_found;
    end else if (revert && better) begin
      sel_d = best_idx;
    end
  end

  // Loop control: holdover on no-activity, same input resumes afterwards
  assign no_activity = lost_sel;
  assign pll_holdover = !ext_mode && (!sel_ok_q || lost_sel);
  assign pll_nearest_edge = sel_ok_q && !pll_holdover;
  wire [2:0] op_state = ext_mode ? OPS_LOCKED :
                        (lost_sel && phase_cfg_q[PHASE_LOST_EN_BIT]) ? OPS_LOST_PHASE :
                        pll_holdover ? OPS_HOLDOVER : OPS_LOCKED;

  // Outputs follow the registered selection; sync pairs with its clock
  assign ref_select = sel_q;
  assign ref_select_valid = sel_ok_q;
  assign sync_select = sel_q;
  assign ref_use_differential = (sel_q != 2'(NUM_IN - 1)) && use_differential_variant[sel_q[0]];

  // Failure flag mirrored on TDO; the scan chain owns the pin otherwise
  assign tdo_out = tdo_en ? lost_flag_q : jtag_tdo;
  assign tdo_oe = tdo_en ? 1'b1 : jtag_tdo_oe;

  // Selection state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_q <= SEL_FIRST;
      sel_ok_q <= 1'b0;
      valid_q <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        pos_q[i] <= 2'h0;
      end
    end else begin
      sel_q <= sel_d;
      sel_ok_q <= sel_ok_d;
      valid_q <= valid_now;
      pos_q <= pos_d;
    end
  end

  // Switch pin sync; strap caught once the chain has settled after reset
  wire strap_take = (init_cnt_q == STRAP_DELAY - 3'h1);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sw_sync_q <= 3'h0;
      sw_q <= 1'b0;
      init_cnt_q <= 3'h0;
      strap_q <= 1'b0;
    end else begin
      sw_sync_q <= {sw_sync_q[1:0], protection_switch_pin};
      if (sw_sync_q[1] == sw_sync_q[2]) begin
        sw_q <= sw_sync_q[2];
      end
      if (init_cnt_q != STRAP_DELAY) begin
        init_cnt_q <= init_cnt_q + 3'h1;
      end
      if (strap_take) begin
        strap_q <= sw_q;
      end
    end
  end

  // Register writes; hardware set wins over a same-cycle clear
  wire wr_int = reg_wr && (reg_addr == ADDR_INT_STATUS);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prio_a_q <= PRIO_A_RST;
      prio_b_q <= PRIO_B_RST;
      prio_c_q <= PRIO_C_RST;
      force_state_q <= FORCE_STATE_RST;
      force_input_q <= FORCE_INPUT_RST;
      tol_one_q <= TOL_NORMAL_CODE;
      tol_two_q <= TOL_NORMAL_CODE;
      mon_cfg_q <= MON_CFG_RST;
      phase_cfg_q <= PHASE_CFG_RST;
      lost_flag_q <= 1'b0;
      reval_q <= '0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          ADDR_PRIO_A: prio_a_q <= reg_wdata;
          ADDR_PRIO_B: prio_b_q <= reg_wdata;
          ADDR_PRIO_C: prio_c_q <= reg_wdata;
          ADDR_FORCE_STATE: force_state_q <= reg_wdata;
          ADDR_FORCE_INPUT: force_input_q <= reg_wdata;
          ADDR_TOL_ONE: tol_one_q <= reg_wdata;
          ADDR_TOL_TWO: tol_two_q <= reg_wdata;
          ADDR_MON_CFG: mon_cfg_q <= reg_wdata;
          ADDR_PHASE_CFG: phase_cfg_q <= reg_wdata;
          default: ;
        endcase
      end
      if (strap_take && sw_q) begin
        tol_one_q <= TOL_WIDE_CODE;
        tol_two_q <= TOL_WIDE_CODE;
      end
      lost_flag_q <= lost_sel | (lost_flag_q & ~(wr_int & reg_wdata[INT_LOST_BIT]));
      reval_q <= rise | (reval_q & ~({NUM_IN{wr_int}} & reg_wdata[NUM_IN-1:0]));
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_INT_STATUS: rd_mux = {1'b0, lost_flag_q, 3'h0, reval_q};
      ADDR_OP_STATE: rd_mux = {5'h00, op_state};
      ADDR_VALID_LO: rd_mux = {5'h00, valid_q};
      ADDR_VALID_HI: rd_mux = {6'h00, use_differential_variant};
      ADDR_PRIO_A: rd_mux = prio_a_q;
      ADDR_PRIO_B: rd_mux = prio_b_q;
      ADDR_PRIO_C: rd_mux = prio_c_q;
      ADDR_FORCE_STATE: rd_mux = force_state_q;
      ADDR_FORCE_INPUT: rd_mux = force_input_q;
      ADDR_TOL_ONE: rd_mux = tol_one_q;
      ADDR_TOL_TWO: rd_mux = tol_two_q;
      ADDR_MON_CFG: rd_mux = mon_cfg_q;
      ADDR_PHASE_CFG: rd_mux = phase_cfg_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_hold_on_loss;
    lost_sel |-> pll_holdover && !pll_nearest_edge;
  endproperty
  a_hold_on_loss: assert property (p_hold_on_loss) else $error("no holdover on loss");
  property p_flag_set;
    lost_sel |=> lost_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lost flag not set");
  property p_phase_report;
    (lost_sel && phase_cfg_q[PHASE_LOST_EN_BIT]) |-> op_state == OPS_LOST_PHASE;
  endproperty
  a_phase_report: assert property (p_phase_report) else $error("phase-lost not reported");
  property p_resume_same;
    (automatic_sel && !uf_en && !revert && lost_sel && elig[sel_q]) |=> $stable(sel_q);
  endproperty
  a_resume_same: assert property (p_resume_same) else $error("switched on brief loss");
  property p_fail_switch;
    (automatic_sel && sel_ok_q && !elig[sel_q] && best_found) |=>
      (sel_q != $past(sel_q)) && sel_ok_q;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("kept failed input");
  property p_nonrevert_keep;
    (automatic_sel && !revert && cur_ok) [*2] |-> $stable(sel_q);
  endproperty
  a_nonrevert_keep: assert property (p_nonrevert_keep) else $error("non-revertive switch");
  property p_equal_no_switch;
    (automatic_sel && cur_ok && !better) |=> $stable(sel_q);
  endproperty
  a_equal_no_switch: assert property (p_equal_no_switch) else $error("switch among equals");
  property p_forced;
    (!ext_mode && forced && force_field <= 4'(NUM_IN)) |=> sel_q == 2'($past(force_field) - 4'h1);
  endproperty
  a_forced: assert property (p_forced) else $error("forced input not taken");
  property p_tdo_mirror;
    tdo_en |-> tdo_oe && (tdo_out == lost_flag_q);
  endproperty
  a_tdo_mirror: assert property (p_tdo_mirror) else $error("TDO not mirroring flag");
  property p_ext_pin;
    (ext_mode && $stable(sw_q)) |=> sel_q == ($past(sw_q) ? SEL_FIRST : SEL_SECOND);
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin selection wrong");
  property p_ext_locked;
    ext_mode |-> (op_state == OPS_LOCKED) && !pll_holdover && !no_activity;
  endproperty
  a_ext_locked: assert property (p_ext_locked) else $error("external mode not locked");

endmodule

`default_nettype wire

// file: rsel_ref_model.sv
`timescale 1ns/1ps
`default_nettype none

// Backplane master, slave and standby sources; a stopped source sticks at its
// last level, which is exactly how a dead reference looks on the pin
module rsel_ref_model #(
  parameter int HALF_NS = 30
) (
  input wire logic [2:0] run,
  output logic [2:0] ref_in,
  output logic [1:0] differential_variant
);
  // Period not a multiple of the system clock, so edges drift against it
  initial begin
    ref_in = 3'h2;
    differential_variant = 2'h1;
    #1; // Keeps every source edge clear of both clock edges
    forever begin
      #(HALF_NS);
      ref_in = ref_in ^ run;
      differential_variant = differential_variant ^ run[1:0];
    end
  end
endmodule

`default_nettype wire

// file: rsel_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rsel_selector_tb;
  import rsel_pkg::*;
  localparam logic [CNT_W-1:0] LOSS = 16'h0028;
  localparam logic [7:0] RA [10] = '{8'h19, 8'h1A, 8'h1C, 8'h32, 8'h33, 8'h48, 8'h73,
    8'h41, 8'h42, 8'h7F};
  localparam logic [7:0] RV [10] = '{8'h21, 8'h03, 8'h00, 8'h08, 8'h0F, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h00};
  logic clk_sys, reset, protection_switch_pin, jtag_tdo, jtag_tdo_oe, reg_wr, reg_rd;
  logic [2:0] run, slow_alarm, ref_in;
  logic [1:0] differential_variant, ref_select, sync_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_rvalid, ref_select_valid, ref_use_differential, no_activity;
  logic pll_holdover, pll_nearest_edge, tdo_out, tdo_oe;
  int failures, checks;

  rsel_ref_model src (.run(run), .ref_in(ref_in), .differential_variant(differential_variant));

  rsel_selector #(.LOSS_CYCLES(LOSS)) dut (.clk_sys(clk_sys), .reset(reset), .ref_in(ref_in),
    .differential_variant(differential_variant), .slow_alarm(slow_alarm),
    .protection_switch_pin(protection_switch_pin), .jtag_tdo(jtag_tdo),
    .jtag_tdo_oe(jtag_tdo_oe), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ref_select(ref_select), .ref_select_valid(ref_select_valid),
    .ref_use_differential(ref_use_differential), .sync_select(sync_select),
    .no_activity(no_activity), .pll_holdover(pll_holdover),
    .pll_nearest_edge(pll_nearest_edge), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One-cycle write strobe; an idle edge follows so back-to-back strobes stay apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    int k;
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    k = 0;
    while (reg_rvalid !== 1'b1 && k < 4) begin
      cyc(1);
      k++;
    end
    if (reg_rvalid !== 1'b1) begin
      failures++;
      give_verdict();
    end
    chk(reg_rdata & m, exp, "register read");
    cyc(1);
  endtask

  // Bounded wait for a selection, then frame sync and valid must agree
  task automatic sel_is(input logic [1:0] exp);
    int k;
    k = 0;
    while (ref_select !== exp && k < 100) begin
      cyc(1);
      k++;
    end
    chk(ref_select, exp, "selection");
    chk(sync_select, exp, "frame sync");
    chk(ref_select_valid, 8'h01, "select valid");
    if (ref_select !== exp) give_verdict();
  endtask

  task automatic wait_act(input logic lvl);
    int k;
    k = 0;
    while (no_activity !== lvl && k < 100) begin
      cyc(1);
      k++;
    end
    chk(no_activity, lvl, "no activity");
    if (no_activity !== lvl) give_verdict();
  endtask

  // Strap pin held through reset and well past release
  task automatic do_reset(input logic pin);
    protection_switch_pin = pin;
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(8);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 10; i++) rchk(RA[i], RV[i], 8'hFF);
    wr(ADDR_VALID_LO, 8'h00);
    rchk(ADDR_VALID_LO, 8'h07, 8'h07);
    chk(tdo_out, jtag_tdo, "tdo idle");
    chk(tdo_oe, jtag_tdo_oe, "tdo oe idle");
  endtask

  task automatic t_auto;
    sel_is(2'h0);
    chk(pll_nearest_edge, 8'h01, "nearest edge");
    slow_alarm = 3'h1;
    sel_is(2'h1);
    slow_alarm = 3'h3;
    sel_is(2'h2);
    slow_alarm = 3'h0;
    sel_is(2'h0);
  endtask

  task automatic t_nonrev;
    wr(ADDR_FORCE_STATE, 8'h00);
    slow_alarm = 3'h1;
    sel_is(2'h1);
    wr(ADDR_INT_STATUS, 8'hFF);
    slow_alarm = 3'h0;
    cyc(10);
    chk(ref_select, 8'h01, "kept");
    rchk(ADDR_INT_STATUS, 8'h01, 8'h07);
    rchk(ADDR_VALID_LO, 8'h07, 8'h07);
    wr(ADDR_FORCE_STATE, 8'h08);
    sel_is(2'h0);
    wr(ADDR_INT_STATUS, 8'hFF);
  endtask

  task automatic t_prio;
    wr(ADDR_PRIO_A, 8'h11);
    slow_alarm = 3'h1;
    sel_is(2'h1);
    slow_alarm = 3'h0;
    cyc(10);
    chk(ref_select, 8'h01, "fifo kept");
    wr(ADDR_PRIO_A, 8'h01);
    sel_is(2'h0);
    slow_alarm = 3'h1;
    sel_is(2'h2);
    slow_alarm = 3'h0;
    wr(ADDR_PRIO_A, 8'h21);
    sel_is(2'h0);
  endtask

  task automatic t_force;
    wr(ADDR_FORCE_INPUT, 8'h02);
    sel_is(2'h1);
    wr(ADDR_FORCE_INPUT, 8'h03);
    sel_is(2'h2);
    wr(ADDR_FORCE_INPUT, 8'h00);
    sel_is(2'h0);
    wr(ADDR_FORCE_INPUT, 8'h0F);
    sel_is(2'h0);
  endtask

  // Selected source stops without ultra-fast, non-revertive: freeze only, then resume
  task automatic t_loss;
    wr(ADDR_FORCE_STATE, 8'h00);
    wr(ADDR_MON_CFG, 8'h40);
    run = 3'h6;
    wait_act(1'b1);
    chk(pll_holdover, 8'h01, "holdover");
    chk(pll_nearest_edge, 8'h00, "edge off");
    chk(ref_select, 8'h00, "no switch");
    cyc(2);
    rchk(ADDR_INT_STATUS, 8'h40, 8'h40);
    rchk(ADDR_OP_STATE, 8'(OPS_HOLDOVER), 8'h07);
    wr(ADDR_PHASE_CFG, 8'h40);
    rchk(ADDR_OP_STATE, 8'(OPS_LOST_PHASE), 8'h07);
    chk({tdo_oe, tdo_out}, 8'h03, "tdo flag");
    run = 3'h7;
    wait_act(1'b0);
    chk(ref_select, 8'h00, "same input");
    chk(pll_nearest_edge, 8'h01, "relocked");
    chk(tdo_out, 8'h01, "tdo held");
    wr(ADDR_INT_STATUS, 8'h40);
    chk(tdo_out, 8'h00, "tdo cleared");
    wr(ADDR_MON_CFG, 8'h00);
    wr(ADDR_PHASE_CFG, 8'h00);
    wr(ADDR_FORCE_STATE, 8'h08);
    chk(tdo_out, jtag_tdo, "tdo back");
  endtask

  task automatic t_ultra;
    wr(ADDR_MON_CFG, 8'h20);
    run = 3'h6;
    sel_is(2'h1);
    rchk(ADDR_INT_STATUS, 8'h40, 8'h40);
    run = 3'h7;
    sel_is(2'h0);
    wr(ADDR_INT_STATUS, 8'hFF);
    wr(ADDR_MON_CFG, 8'h00);
  endtask

  task automatic t_ext;
    wr(ADDR_MON_CFG, 8'h10);
    protection_switch_pin = 1'b1;
    sel_is(2'h0);
    protection_switch_pin = 1'b0;
    sel_is(2'h1);
    run = 3'h5;
    cyc(60);
    chk({no_activity, pll_holdover}, 8'h00, "monitor off");
    chk(ref_select, 8'h01, "forced lock");
    rchk(ADDR_OP_STATE, 8'(OPS_LOCKED), 8'h07);
    chk(ref_use_differential, 8'h00, "single ended");
    wr(ADDR_PRIO_A, 8'h01);
    cyc(2);
    chk(ref_use_differential, 8'h01, "differential");
    run = 3'h7;
    wr(ADDR_PRIO_A, 8'h21);
    wr(ADDR_MON_CFG, 8'h00);
  endtask

  task automatic t_strap;
    do_reset(1'b1);
    rchk(ADDR_TOL_ONE, TOL_WIDE_CODE, 8'hFF);
    rchk(ADDR_TOL_TWO, TOL_WIDE_CODE, 8'hFF);
    sel_is(2'h0);
    protection_switch_pin = 1'b0;
    sel_is(2'h1);
    wr(ADDR_TOL_ONE, TOL_NORMAL_CODE);
    rchk(ADDR_TOL_ONE, TOL_NORMAL_CODE, 8'hFF);
    do_reset(1'b0);
    rchk(ADDR_TOL_TWO, TOL_NORMAL_CODE, 8'hFF);
  endtask

  // Hang guard
  initial begin
    #500000;
    failures++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    slow_alarm = 3'h0;
    run = 3'h7;
    protection_switch_pin = 1'b0;
    jtag_tdo = 1'b1;
    jtag_tdo_oe = 1'b1;
    failures = 0;
    checks = 0;
    cyc(1);
    do_reset(1'b0);
    t_reset();
    t_auto();
    t_nonrev();
    t_prio();
    t_force();
    t_loss();
    t_ultra();
    t_ext();
    t_strap();
    give_verdict();
  end
endmodule

`default_nettype wire
